// [inc/dmpi_pkg.sv]
package dmpi_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BANK_W = 3;
    localparam int CS_W   = 4;
    localparam int BYTES  = 2;

    // ****************************************
    // command encodings {ras_n, cas_n, we_n}
    // ****************************************
    localparam logic [2:0] CMD_LMR  = 3'h0;
    localparam logic [2:0] CMD_REF  = 3'h1;
    localparam logic [2:0] CMD_PRE  = 3'h2;
    localparam logic [2:0] CMD_ACT  = 3'h3;
    localparam logic [2:0] CMD_WR   = 3'h4;
    localparam logic [2:0] CMD_RD   = 3'h5;
    localparam logic [2:0] CMD_NOP  = 3'h7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [CS_W-1:0] CS_IDLE = 4'hF;
    localparam logic [1:0] CHIP_SEL_LSB = 2'h0;
    // core cycles, plus one, the write level stays up; must outlast two link periods
    localparam logic [3:0] WR_HOLD = 4'h6;

    typedef enum logic [1:0] {DMPI_IDLE, DMPI_CMD, DMPI_WDATA, DMPI_RDATA} dmpi_state_t;

    // core-side request
    typedef struct packed {
        logic              valid;
        logic [2:0]        cmd;
        logic [1:0]        chip;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } dmpi_req_t;

    // one write beat pair (rising, falling)
    typedef struct packed {
        logic [DATA_W-1:0] dataRise;
        logic [DATA_W-1:0] dataFall;
        logic [BYTES-1:0]  maskRise;
        logic [BYTES-1:0]  maskFall;
    } dmpi_wbeat_t;

    // software configuration bits
    typedef struct packed {
        logic       cke;
        logic       odt;
        logic       dqsDiff;
        logic [1:0] clkEn;
    } dmpi_cfg_t;

    // memory command pins
    typedef struct packed {
        logic [CS_W-1:0]   csN;
        logic              rasN;
        logic              casN;
        logic              weN;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic              cke;
        logic              odt;
    } dmpi_cmdpins_t;

endpackage

// [src/dmpi_data_link.sv]
`timescale 1ns/1ps
`default_nettype none
// data side on the link clock: drives write beats, captures reads
module dmpi_data_link (
    // link clock and reset
    input  wire logic                      memClk,
    input  wire logic                      linkRst,
    // beat to send
    input  wire logic                      wrActive,
    input  wire dmpi_pkg::dmpi_wbeat_t     wrBeat,
    input  wire logic                      dqsDiff,
    // pins
    input  wire logic [dmpi_pkg::DATA_W-1:0] dqIn,
    output logic      [dmpi_pkg::DATA_W-1:0] dqOut,
    output logic      [dmpi_pkg::DATA_W-1:0] dqOe,
    output logic      [dmpi_pkg::BYTES-1:0]  dqsOut,
    output logic      [dmpi_pkg::BYTES-1:0]  dqsNOut,
    output logic      [dmpi_pkg::BYTES-1:0]  dqsOe,
    output logic      [dmpi_pkg::BYTES-1:0]  dmOut,
    // captured read word
    output logic      [dmpi_pkg::DATA_W-1:0] rdWord
);
    typedef struct packed {
        logic [dmpi_pkg::DATA_W-1:0] dq;
        logic                        oe;
        logic                        phase;
        logic [dmpi_pkg::BYTES-1:0]  dm;
        logic [dmpi_pkg::DATA_W-1:0] rd;
    } dmpi_link_t;

    dmpi_link_t st_reg;
    dmpi_link_t st_next;

    // one beat per rising link edge; two halves alternate each cycle
    always_comb begin
        st_next       = st_reg;
        st_next.phase = ~st_reg.phase;
        st_next.oe    = wrActive;
        st_next.dq    = st_reg.phase ? wrBeat.dataFall : wrBeat.dataRise;
        st_next.dm    = st_reg.phase ? wrBeat.maskFall : wrBeat.maskRise;
        if (!wrActive) begin
            st_next.rd = dqIn;
        end
        if (linkRst) begin
            st_next = '0;
        end
    end

    always_ff @(posedge memClk) begin
        st_reg <= st_next;
    end

    always_comb begin
        dqOut   = st_reg.dq;
        dqOe    = {dmpi_pkg::DATA_W{st_reg.oe}};
        dmOut   = st_reg.oe ? st_reg.dm : {dmpi_pkg::BYTES{1'b1}};
        dqsOut  = {dmpi_pkg::BYTES{st_reg.phase}};
        dqsNOut = dqsDiff ? ~dqsOut : {dmpi_pkg::BYTES{1'b0}};
        dqsOe   = {dmpi_pkg::BYTES{st_reg.oe}};
        rdWord  = st_reg.rd;
    end
endmodule
`default_nettype wire

// [src/dmpi_pin_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// memory pin interface top
// ****************************************
module dmpi_pin_if (
    // clocks and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        memClk,
    // configuration bits (memory_ctrl_cfg_zero / memory_ctrl_cfg_three)
    input  wire dmpi_pkg::dmpi_cfg_t         cfg,
    // command request
    input  wire dmpi_pkg::dmpi_req_t         req,
    output logic                             reqReady,
    // write data
    input  wire dmpi_pkg::dmpi_wbeat_t       wrBeat,
    // read data
    output logic [dmpi_pkg::DATA_W-1:0]      rdData,
    // command pins
    output dmpi_pkg::dmpi_cmdpins_t          cmdPins,
    output logic                             cmdOe,
    // clock pins
    output logic [1:0]                       memClkP,
    output logic [1:0]                       memClkN,
    output logic [1:0]                       memClkOe,
    // data pins
    input  wire logic [dmpi_pkg::DATA_W-1:0] dqIn,
    output logic      [dmpi_pkg::DATA_W-1:0] dqOut,
    output logic      [dmpi_pkg::DATA_W-1:0] dqOe,
    output logic      [dmpi_pkg::BYTES-1:0]  dqsOut,
    output logic      [dmpi_pkg::BYTES-1:0]  dqsNOut,
    output logic      [dmpi_pkg::BYTES-1:0]  dqsOe,
    output logic      [dmpi_pkg::BYTES-1:0]  dmOut
);
    // ****************************************
    // core state
    // ****************************************
    typedef struct packed {
        dmpi_pkg::dmpi_state_t   fsm;
        dmpi_pkg::dmpi_cmdpins_t pins;
        logic                    wrTgl;
        logic                    wrLvl;
        logic [3:0]              wrCnt;
        logic [dmpi_pkg::DATA_W-1:0] rd1;
        logic [dmpi_pkg::DATA_W-1:0] rd2;
        logic [1:0]              clkEn1;
        logic [1:0]              clkEn2;
    } dmpi_core_t;

    dmpi_core_t st_reg;
    dmpi_core_t st_next;

    // ****************************************
    // link reset/write crossings
    // ****************************************
    logic [1:0] lrst_reg;
    logic [1:0] lwr_reg;
    logic       linkRst;
    logic       wrActive;
    logic [dmpi_pkg::DATA_W-1:0] rdWord;

    // one-hot active-low select from chip index
    function automatic logic [dmpi_pkg::CS_W-1:0] csDecode(input logic [1:0] chip);
        logic [dmpi_pkg::CS_W-1:0] v;
        v = dmpi_pkg::CS_IDLE;
        v[chip] = 1'b0;
        return v;
    endfunction

    // core fsm: one command per request, write/read held one cycle
    always_comb begin
        st_next        = st_reg;
        st_next.rd1    = rdWord;
        st_next.rd2    = st_reg.rd1;
        st_next.clkEn1 = cfg.clkEn;
        st_next.clkEn2 = st_reg.clkEn1;
        st_next.pins.cke  = cfg.cke;
        st_next.pins.odt  = cfg.odt;
        st_next.pins.csN  = dmpi_pkg::CS_IDLE;
        {st_next.pins.rasN, st_next.pins.casN, st_next.pins.weN} = dmpi_pkg::CMD_NOP;
        // stretched so the slower link clock cannot miss the write
        st_next.wrLvl = (st_reg.wrCnt != 4'h0);
        if (st_reg.wrCnt != 4'h0) begin
            st_next.wrCnt = st_reg.wrCnt - 4'h1;
        end
        case (st_reg.fsm)
            dmpi_pkg::DMPI_IDLE: begin
                if (req.valid) begin
                    {st_next.pins.rasN, st_next.pins.casN, st_next.pins.weN} = req.cmd;
                    st_next.pins.csN = csDecode(req.chip);
                    st_next.pins.ba  = req.bank;
                    st_next.pins.addr = req.addr;
                    if (req.cmd == dmpi_pkg::CMD_WR) begin
                        st_next.fsm = dmpi_pkg::DMPI_WDATA;
                    end else if (req.cmd == dmpi_pkg::CMD_RD) begin
                        st_next.fsm = dmpi_pkg::DMPI_RDATA;
                    end else begin
                        st_next.fsm = dmpi_pkg::DMPI_CMD;
                    end
                end
            end
            dmpi_pkg::DMPI_CMD: begin
                st_next.fsm = dmpi_pkg::DMPI_IDLE;
            end
            dmpi_pkg::DMPI_WDATA: begin
                // level crosses to link domain, two flops there
                st_next.wrLvl = 1'b1;
                st_next.wrCnt = dmpi_pkg::WR_HOLD;
                st_next.fsm   = dmpi_pkg::DMPI_IDLE;
            end
            dmpi_pkg::DMPI_RDATA: begin
                st_next.fsm = dmpi_pkg::DMPI_IDLE;
            end
            default: begin
                st_next.fsm = dmpi_pkg::DMPI_IDLE;
            end
        endcase
        if (rst) begin
            st_next = '0;
            st_next.fsm = dmpi_pkg::DMPI_IDLE;
            st_next.pins.csN = dmpi_pkg::CS_IDLE;
            {st_next.pins.rasN, st_next.pins.casN, st_next.pins.weN} = dmpi_pkg::CMD_NOP;
        end
    end

    always_ff @(posedge core_clk) begin
        st_reg <= st_next;
    end

    // reset and write level synchronised into link domain
    always_ff @(posedge memClk) begin
        lrst_reg <= {lrst_reg[0], rst};
        lwr_reg  <= {lwr_reg[0], st_reg.wrLvl};
    end
    assign linkRst  = lrst_reg[1];
    assign wrActive = lwr_reg[1];

    dmpi_data_link u_link (
        .memClk   (memClk),
        .linkRst  (linkRst),
        .wrActive (wrActive),
        .wrBeat   (wrBeat),
        .dqsDiff  (cfg.dqsDiff),
        .dqIn     (dqIn),
        .dqOut    (dqOut),
        .dqOe     (dqOe),
        .dqsOut   (dqsOut),
        .dqsNOut  (dqsNOut),
        .dqsOe    (dqsOe),
        .dmOut    (dmOut),
        .rdWord   (rdWord)
    );

    // outputs
    assign reqReady = (st_reg.fsm == dmpi_pkg::DMPI_IDLE) && !rst;
    assign rdData   = st_reg.rd2;
    assign cmdPins  = st_reg.pins;
    assign cmdOe    = 1'b1;
    assign memClkP  = {memClk, memClk};
    assign memClkN  = {~memClk, ~memClk};
    assign memClkOe = st_reg.clkEn2;
endmodule
`default_nettype wire

// [verif/dmpi_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// memory device model
// ****************************************
module dmpi_mem_model (
    // observation clock and command pins
    input  wire logic                    cmdClk,
    input  wire dmpi_pkg::dmpi_cmdpins_t cmdPins,
    input  wire logic [15:0]             rdWord,
    // read data toward controller
    output logic      [15:0]             dqIn
);
    logic [4:0] burst = 5'h0;
    // only a selected read command starts a burst
    always @(posedge cmdClk) begin
        if (cmdPins.csN != 4'hF && {cmdPins.rasN, cmdPins.casN, cmdPins.weN} == dmpi_pkg::CMD_RD) begin
            burst <= 5'h18;
        end else if (burst != 5'h0) begin
            burst <= burst - 5'h1;
        end
    end
    // released bus shows the inverse so stale data never matches
    assign dqIn = (burst != 5'h0) ? rdWord : ~rdWord;
endmodule
`default_nettype wire

// [verif/dmpi_pin_if_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pin checker
// ****************************************
module dmpi_pin_if_sva (
    // clocks and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  memClk,
    // core side
    input wire dmpi_pkg::dmpi_cfg_t   cfg,
    input wire dmpi_pkg::dmpi_req_t   req,
    input wire logic                  reqReady,
    // pins
    input wire dmpi_pkg::dmpi_cmdpins_t cmdPins,
    input wire logic [1:0]            memClkP,
    input wire logic [1:0]            memClkN,
    input wire logic [1:0]            memClkOe,
    input wire logic [15:0]           dqOe,
    input wire logic [1:0]            dqsOe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // taken request shapes the pins one cycle later
    AST_CMD_CODE: assert property (req.valid && reqReady |=> {cmdPins.rasN, cmdPins.casN, cmdPins.weN} == $past(req.cmd))
        else $error("command code wrong");
    AST_BANK: assert property (req.valid && reqReady |=> cmdPins.ba == $past(req.bank))
        else $error("bank wrong");
    AST_ADDR: assert property (req.valid && reqReady |=> cmdPins.addr == $past(req.addr))
        else $error("address wrong");
    AST_SEL: assert property (req.valid && reqReady |=> cmdPins.csN == ~(4'h1 << $past(req.chip)))
        else $error("select wrong");
    AST_NOP: assert property (req.valid && reqReady |=> ##1 cmdPins.csN == 4'hF)
        else $error("select left low");
    AST_CFG_LVL: assert property ($stable(cfg)[*3] |-> cmdPins.cke == cfg.cke && cmdPins.odt == cfg.odt)
        else $error("enable level wrong");
    AST_CLK_OE: assert property ($stable(cfg.clkEn)[*5] |-> memClkOe == cfg.clkEn)
        else $error("clock enable wrong");
    // clocks keep running through reset
    AST_CLK_RUN: assert property (disable iff (1'b0) memClkP == {2{memClk}} && memClkN == ~memClkP)
        else $error("memory clock wrong");
    AST_RST_IDLE: assert property (disable iff (1'b0) rst[*6] ##1 rst[*6] |-> cmdPins.csN == 4'hF
        && {cmdPins.rasN, cmdPins.casN, cmdPins.weN} == 3'h7 && !cmdPins.cke && dqOe == 16'h0)
        else $error("reset state wrong");
    AST_DQS_WITH: assert property (@(posedge memClk) disable iff (rst) dqOe != 16'h0 |-> dqsOe == 2'h3)
        else $error("strobe not driven");
endmodule
bind dmpi_pin_if dmpi_pin_if_sva i_sva (.core_clk, .rst, .memClk, .cfg, .req, .reqReady, .cmdPins,
    .memClkP, .memClkN, .memClkOe, .dqOe, .dqsOe);
`default_nettype wire

// [verif/test_dmpi_pin_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pin interface bench
// ****************************************
module test_dmpi_pin_if;
    logic core_clk = 1'b0;
    logic memClk   = 1'b0;
    logic rst      = 1'b1;
    dmpi_pkg::dmpi_cfg_t     cfg = '{1'b1, 1'b1, 1'b1, 2'h3};
    dmpi_pkg::dmpi_req_t     req = '0;
    dmpi_pkg::dmpi_wbeat_t   wrBeat = '0;
    dmpi_pkg::dmpi_cmdpins_t cmdPins;
    logic [15:0] rdWord = 16'h0;
    logic [15:0] rdData, dqIn, dqOut, dqOe;
    logic [1:0]  memClkP, memClkN, memClkOe, dqsOut, dqsNOut, dqsOe, dmOut;
    logic        reqReady, cmdOe;
    int          fails = 0;
    int          num_checks = 0;
    logic [2:0]  cmds [6] = '{dmpi_pkg::CMD_LMR, dmpi_pkg::CMD_REF, dmpi_pkg::CMD_PRE,
                              dmpi_pkg::CMD_ACT, dmpi_pkg::CMD_WR, dmpi_pkg::CMD_RD};
    // clocks, link one offset so edges never line up
    always #2.5 core_clk = ~core_clk;
    initial begin
        #1.1;
        forever #7.5 memClk = ~memClk;
    end
    dmpi_pin_if i_dut (.core_clk, .rst, .memClk, .cfg, .req, .reqReady, .wrBeat, .rdData, .cmdPins, .cmdOe,
        .memClkP, .memClkN, .memClkOe, .dqIn, .dqOut, .dqOe, .dqsOut, .dqsNOut, .dqsOe, .dmOut);
    dmpi_mem_model i_mem (.cmdClk(core_clk), .cmdPins, .rdWord, .dqIn);
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input logic [35:0] exp, input logic [35:0] got);
        num_checks++;
        if (exp !== got) begin
            fails++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // pins expected for a request under the current levels
    function automatic dmpi_pkg::dmpi_cmdpins_t expPins(input dmpi_pkg::dmpi_req_t r);
        return '{~(4'h1 << r.chip), r.cmd[2], r.cmd[1], r.cmd[0], r.bank, r.addr, cfg.cke, cfg.odt};
    endfunction
    // one request, pins checked on the answer cycle and the select on the idle cycle after
    task automatic issue(input logic [2:0] c);
        dmpi_pkg::dmpi_req_t r;
        r = '{1'b1, c, 2'($urandom), 3'($urandom), 16'($urandom)};
        @(posedge core_clk) req <= r;
        @(posedge core_clk) req.valid <= 1'b0;
        #1 cmp(expPins(r), cmdPins);
        @(posedge core_clk);
        #1 cmp(4'hF, cmdPins.csN);
    endtask
    // wait for the link to drive a write beat
    task automatic waitBeat;
        for (int n = 0; n < 60 && dqOe === 16'h0; n++) @(posedge memClk) #1;
        if (dqOe === 16'h0) begin
            fails++;
            summarize;
        end
    endtask
    initial begin
        void'($urandom(32078));
        repeat (16) @(posedge core_clk);
        #1 cmp({4'hF, 1'b0, 16'h0}, {cmdPins.csN, cmdPins.cke, dqOe});
        @(posedge core_clk) rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 60; i++) issue(cmds[i % 6]);
        $display("test commands done");
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) cfg <= '{i[0], i[1], 1'b1, 2'(i)};
            repeat (10) @(posedge core_clk);
            #1 cmp({i[0], i[1], 2'(i)}, {cmdPins.cke, cmdPins.odt, memClkOe});
        end
        $display("test config done");
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk) wrBeat <= 36'({$urandom, $urandom});
            issue(dmpi_pkg::CMD_WR);
            waitBeat;
            cmp({16'hFFFF, 2'h3, ~dqsOut}, {dqOe, dqsOe, dqsNOut});
            cmp((dqOut === wrBeat.dataRise) ? {wrBeat.dataRise, wrBeat.maskRise} : {wrBeat.dataFall, wrBeat.maskFall},
                {dqOut, dmOut});
        end
        $display("test writes done");
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) rdWord <= 16'($urandom);
            issue(dmpi_pkg::CMD_RD);
            for (int n = 0; n < 60 && rdData !== rdWord; n++) @(posedge core_clk) #1;
            cmp(rdWord, rdData);
        end
        $display("test reads done");
        summarize;
    end
endmodule
`default_nettype wire
